/* File: lsfh_cfg.svh */
// Timing and sizing constants for the LED string fault handler.
// Assumes a 100 MHz system clock; included by its bare name.
`ifndef LSFH_CFG_SVH
`define LSFH_CFG_SVH

`define LSFH_CLK_MHZ        100
`define LSFH_NUM_STRINGS    4
// Partial-short detection time in ns and in clock cycles
`define LSFH_DETECT_NS      2000
`define LSFH_DETECT_CYC     ((`LSFH_DETECT_NS * `LSFH_CLK_MHZ) / 1000)
`define LSFH_DET_W          8
// Latch-clear low time in us and in clock cycles
`define LSFH_UNLATCH_US     16000
`define LSFH_UNLATCH_CYC    (`LSFH_UNLATCH_US * `LSFH_CLK_MHZ)
`define LSFH_UNL_W          21

`endif

/* File: lsfh_pkg.sv */
// Types shared by the LED string fault handler modules.
// Assumes lsfh_cfg.svh is on the include path.
`include "lsfh_cfg.svh"

package lsfh_pkg;

  typedef enum logic [0:0] {
    LSFH_MODE_ISOLATE  = 1'b0,
    LSFH_MODE_SHUT_ALL = 1'b1
  } lsfh_mode_t;

  typedef enum logic [1:0] {
    LSFH_STR_OK      = 2'b00,
    LSFH_STR_OFF     = 2'b01,
    LSFH_STR_RETRY   = 2'b10,
    LSFH_STR_PASSED  = 2'b11
  } lsfh_str_state_t;

  typedef logic [`LSFH_NUM_STRINGS-1:0] lsfh_vec_t;

endpackage

/* File: lsfh_str_if.sv */
// Per-string signals between the top and the string monitors.
// Assumes one clock domain shared by all parties.
interface lsfh_str_if;
  import lsfh_pkg::*;
  lsfh_vec_t pwm_edge;
  lsfh_vec_t above_thr;
  lsfh_vec_t regulating;
  lsfh_vec_t other_low;
  lsfh_vec_t sink_en;
  lsfh_vec_t short_hit;
  lsfh_vec_t flag_hold;

  modport ctrl (
    output pwm_edge,
    output above_thr,
    output regulating,
    output other_low,
    input  sink_en,
    input  short_hit,
    input  flag_hold
  );
  modport mon (
    input  pwm_edge,
    input  above_thr,
    input  regulating,
    input  other_low,
    output sink_en,
    output short_hit,
    output flag_hold
  );
endinterface

/* File: lsfh_str_mon.sv */
// One partial-short monitor per LED string, looped by a generate.
// Assumes the top supplies qualified comparator levels and PWM edges.
`include "lsfh_cfg.svh"

module lsfh_str_mon
  import lsfh_pkg::*;
(
  input  wire logic  sys_clk_in,
  input  wire logic  srst_in,
  input  wire logic  clk_en_in,
  input  wire logic  pwm_in,
  lsfh_str_if.mon    str
);

  typedef struct packed {
    lsfh_str_state_t         st;
    logic [`LSFH_DET_W-1:0]  cnt;
  } lsfh_mon_state_t;

  localparam logic [`LSFH_DET_W-1:0] DET_CYC =
    `LSFH_DET_W'(`LSFH_DETECT_CYC);

  genvar gi;
  generate
    for (gi = 0; gi < `LSFH_NUM_STRINGS; gi++) begin : g_str
      lsfh_mon_state_t s;
      lsfh_mon_state_t next_s;
      logic            cond;

      // Evaluation only while PWM is high
      assign cond = pwm_in & str.above_thr[gi] & str.regulating[gi]
                    & str.other_low[gi];

      always_comb begin
        next_s = s;
        unique case (s.st)
          LSFH_STR_OK, LSFH_STR_RETRY, LSFH_STR_PASSED: begin
            if (cond) begin
              if (s.cnt >= DET_CYC - `LSFH_DET_W'(1)) begin
                next_s.st  = LSFH_STR_OFF;
                next_s.cnt = '0;
              end else begin
                next_s.cnt = s.cnt + `LSFH_DET_W'(1);
              end
            end else begin
              next_s.cnt = '0;
            end
            if (str.pwm_edge[gi] && !cond) begin
              if (s.st == LSFH_STR_RETRY) begin
                next_s.st = LSFH_STR_PASSED;
              end else if (s.st == LSFH_STR_PASSED) begin
                next_s.st = LSFH_STR_OK;
              end
            end
          end
          LSFH_STR_OFF: begin
            next_s.cnt = '0;
            // Retry if still short, else counts as passed
            if (str.pwm_edge[gi]) begin
              next_s.st = cond ? LSFH_STR_RETRY
                               : LSFH_STR_PASSED;
            end
          end
        endcase
        if (srst_in) begin
          next_s = '0;
        end
      end

      always_ff @(posedge sys_clk_in) begin
        if (clk_en_in || srst_in) begin
          s <= next_s;
        end
      end

      assign str.sink_en[gi]   = (s.st != LSFH_STR_OFF);
      assign str.short_hit[gi] = (s.st != LSFH_STR_OFF) && cond
                                 && (s.cnt >= DET_CYC - `LSFH_DET_W'(1));
      assign str.flag_hold[gi] = (s.st != LSFH_STR_OK);
    end
  endgenerate

endmodule

/* File: lsfh_unlatch.sv */
// Measures how long enable or PWM has stayed low.
// Assumes enable and PWM are synchronous to the clock.
`include "lsfh_cfg.svh"

module lsfh_unlatch
  import lsfh_pkg::*;
#(
  parameter int unsigned UNLATCH_CYC = `LSFH_UNLATCH_CYC
) (
  input  wire logic  sys_clk_in,
  input  wire logic  srst_in,
  input  wire logic  clk_en_in,
  input  wire logic  low_in,
  output logic       expired_out
);

  typedef struct packed {
    logic [`LSFH_UNL_W-1:0] cnt;
    logic                   done;
  } lsfh_unl_state_t;

  localparam logic [`LSFH_UNL_W-1:0] LIMIT =
    `LSFH_UNL_W'(UNLATCH_CYC - 1);

  lsfh_unl_state_t s;
  lsfh_unl_state_t next_s;

  always_comb begin
    next_s = s;
    if (!low_in) begin
      next_s = '0;
    end else if (s.cnt >= LIMIT) begin
      next_s.done = 1'b1;
    end else begin
      next_s.cnt = s.cnt + `LSFH_UNL_W'(1);
    end
    if (srst_in) begin
      next_s = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in || srst_in) begin
      s <= next_s;
    end
  end

  assign expired_out = s.done;

endmodule

/* File: lsfh_top.sv */
// Top of the LED string fault handler: fault line, shutdown, latching.
// Assumes all inputs are synchronous to sys_clk_in; analog
// comparators arrive as levels per string.
`include "lsfh_cfg.svh"

// Behaviour
// - Isolate mode ignores external fault-line low.
// - Shut-all mode drives and senses fault line.
// - External low stops boost, sinks; disconnect kept.
// - Restart after external release and no fault.
// - External high never clears latched faults.
// - Short evaluated only while PWM high.
// - After detect time disable string, pull line.
// - Each PWM rising edge retries disabled string.
// - Passed retry resumes string, flag kept.
// - Flag released second edge after removal.
// - Short needs regulation and another pin low.
// - Shut-all short latches off; long low clears.
module lsfh_top
  import lsfh_pkg::*;
#(
  parameter int unsigned UNLATCH_CYC = `LSFH_UNLATCH_CYC
) (
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  input  wire logic       clk_en_in,
  input  wire logic       mode_shut_all_in,
  input  wire logic       enable_in,
  input  wire logic       pwm_in,
  input  wire lsfh_vec_t  above_thr_in,
  input  wire lsfh_vec_t  regulating_in,
  input  wire lsfh_vec_t  below_low_in,
  input  wire logic       fault_line_in,
  output logic            fault_line_out,
  output logic            fault_line_oe_out,
  output logic            boost_en_out,
  output logic            disconnect_on_out,
  output lsfh_vec_t       sink_en_out,
  output logic            latched_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic       pwm_q;
    logic       latched;
    logic       ext_hold;
    logic       flag;
    logic       boost_en;
    logic       disc_on;
    lsfh_vec_t  sink_en;
  } lsfh_top_state_t;

  lsfh_top_state_t s;
  lsfh_top_state_t next_s;

  lsfh_str_if str ();

  logic       mode_shut;
  logic       ext_low;
  logic       unlatch;
  logic       any_hit;
  logic       any_hold;
  logic       pwm_rise;

  assign mode_shut = mode_shut_all_in;
  assign pwm_rise  = pwm_in & ~s.pwm_q;

  // Line sensed only in shut-all mode; own drive excluded
  assign ext_low   = mode_shut & ~fault_line_in & ~s.flag;

  // ****************************************************************
  // Per-string qualification
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `LSFH_NUM_STRINGS; gi++) begin : g_q
      lsfh_vec_t others;
      always_comb begin
        others     = below_low_in;
        others[gi] = 1'b0;
      end
      assign str.pwm_edge[gi]   = pwm_rise;
      assign str.above_thr[gi]  = above_thr_in[gi];
      assign str.regulating[gi] = regulating_in[gi];
      assign str.other_low[gi]  = |others;
    end
  endgenerate

  assign any_hit  = |str.short_hit;
  assign any_hold = |str.flag_hold;

  lsfh_str_mon u_mon (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .clk_en_in  (clk_en_in),
    .pwm_in     (pwm_in),
    .str        (str.mon)
  );

  lsfh_unlatch #(
    .UNLATCH_CYC (UNLATCH_CYC)
  ) u_unlatch (
    .sys_clk_in  (sys_clk_in),
    .srst_in     (srst_in),
    .clk_en_in   (clk_en_in),
    .low_in      (~enable_in | ~pwm_in),
    .expired_out (unlatch)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s       = s;
    next_s.pwm_q = pwm_in;

    // Latch off all strings on a short in shut-all mode
    if (mode_shut && any_hit) begin
      next_s.latched = 1'b1;
    end else if (unlatch) begin
      next_s.latched = 1'b0;
    end

    next_s.ext_hold = ext_low;

    // Flag follows own faults only, never the external line
    if (mode_shut) begin
      next_s.flag = next_s.latched;
    end else begin
      next_s.flag = any_hold | any_hit;
    end

    if (next_s.latched) begin
      next_s.boost_en = 1'b0;
      next_s.disc_on  = 1'b0;
      next_s.sink_en  = '0;
    end else if (ext_low) begin
      next_s.boost_en = 1'b0;
      next_s.disc_on  = 1'b1;
      next_s.sink_en  = '0;
    end else begin
      // Restart once line released and nothing pending
      next_s.boost_en = 1'b1;
      next_s.disc_on  = 1'b1;
      next_s.sink_en  = mode_shut ? '1 : str.sink_en;
      if (!mode_shut) begin
        next_s.sink_en = next_s.sink_en & ~str.short_hit;
      end
    end

    if (srst_in) begin
      next_s = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in || srst_in) begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign fault_line_out    = 1'b0;
  assign fault_line_oe_out = s.flag;
  assign boost_en_out      = s.boost_en;
  assign disconnect_on_out = s.disc_on;
  assign sink_en_out       = s.sink_en;
  assign latched_out       = s.latched;

endmodule

/* File: lsfh_top_sva.sv */
// Concurrent checks on the fault handler top.
// Assumes it is bound to lsfh_top and sees only its ports.
`include "lsfh_cfg.svh"

module lsfh_top_sva
  import lsfh_pkg::*;
#(
  parameter int unsigned UNLATCH_CYC = `LSFH_UNLATCH_CYC
) (
  input wire logic      sys_clk_in,
  input wire logic      srst_in,
  input wire logic      mode_shut_all_in,
  input wire logic      enable_in,
  input wire logic      pwm_in,
  input wire lsfh_vec_t above_thr_in,
  input wire lsfh_vec_t regulating_in,
  input wire lsfh_vec_t below_low_in,
  input wire logic      fault_line_in,
  input wire logic      fault_line_out,
  input wire logic      fault_line_oe_out,
  input wire logic      boost_en_out,
  input wire logic      disconnect_on_out,
  input wire lsfh_vec_t sink_en_out,
  input wire logic      latched_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // *****
  // Short condition and low-time counters for string 0
  // *****
  logic [8:0] cnt;
  int         ucnt;
  logic [2:0] pwm_d;
  wire        cond0 = pwm_in && above_thr_in[0] && regulating_in[0] &&
                      (|below_low_in[3:1]);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cnt   <= 9'h000;
      ucnt  <= 0;
      pwm_d <= 3'h0;
    end else begin
      cnt   <= cond0 ? cnt + 9'h001 : 9'h000;
      ucnt  <= (enable_in && pwm_in) ? 0 : ucnt + 1;
      pwm_d <= {pwm_d[1:0], pwm_in};
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_off;
    !boost_en_out && sink_en_out == 4'h0;
  endsequence
  property p_iso;
    !mode_shut_all_in && boost_en_out |=> boost_en_out;
  endproperty
  property p_flag;
    mode_shut_all_in |-> fault_line_oe_out == latched_out && !fault_line_out;
  endproperty
  property p_ext;
    mode_shut_all_in && !fault_line_in && !fault_line_oe_out
      |=> s_off ##0 disconnect_on_out && !fault_line_oe_out;
  endproperty
  property p_rst;
    mode_shut_all_in && enable_in && fault_line_in && !fault_line_oe_out &&
      above_thr_in == 4'h0 |=> boost_en_out;
  endproperty
  property p_hold;
    latched_out && enable_in && pwm_in |=> latched_out;
  endproperty
  property p_det;
    !mode_shut_all_in && enable_in && cnt == 9'h0C8
      |-> ##[0:2] !sink_en_out[0] && fault_line_oe_out;
  endproperty
  property p_retry;
    !mode_shut_all_in && $rose(pwm_in) && !sink_en_out[0]
      |-> ##[1:2] sink_en_out[0];
  endproperty
  property p_fall;
    !mode_shut_all_in && $fell(fault_line_oe_out)
      |-> (pwm_d[0] && !pwm_d[1]) || (pwm_d[1] && !pwm_d[2]);
  endproperty
  property p_latch;
    mode_shut_all_in && enable_in && cnt == 9'h0C8
      |-> ##[0:2] latched_out ##0 s_off;
  endproperty
  property p_unl;
    ucnt > UNLATCH_CYC + 3 |-> !latched_out;
  endproperty

  a_iso: assert property (p_iso) else $error("boost lost");
  a_flag: assert property (p_flag) else $error("flag wrong");
  a_ext: assert property (p_ext) else $error("no shutdown");
  a_rst: assert property (p_rst) else $error("no restart");
  a_hold: assert property (p_hold) else $error("latch lost");
  a_det: assert property (p_det) else $error("no cut");
  a_retry: assert property (p_retry) else $error("no retry");
  a_fall: assert property (p_fall) else $error("early clear");
  a_latch: assert property (p_latch) else $error("no latch");
  a_unl: assert property (p_unl) else $error("latch stuck");
endmodule

/* File: lsfh_host_model.sv */
// Host side of the shared open-drain fault line.
// Assumes the device pin arrives split into data and enable.
module lsfh_host_model (
  input  wire logic pull_low_in,
  input  wire logic force_high_in,
  input  wire logic dev_oe_in,
  input  wire logic dev_data_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // *****
  // Wire level with pull-up
  // *****
  assign line_out = force_high_in ? 1'h1
                  : !(pull_low_in || (dev_oe_in && !dev_data_in));
endmodule

/* File: test_lsfh_top.sv */
// Self-checking bench for the fault handler top.
// Assumes the host model on the fault line and a short latch-clear time.
module test_lsfh_top
  import lsfh_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned UNL = 50;
  logic      sys_clk_in = 1'h0;
  logic      srst_in = 1'h1;
  logic      mode = 1'h0;
  logic      enable = 1'h1;
  logic      pwm = 1'h0;
  lsfh_vec_t above = 4'h0;
  lsfh_vec_t below = 4'h0;
  lsfh_vec_t regul = 4'hF;
  logic      pull = 1'h0;
  logic      force_hi = 1'h0;
  logic      line, fl_out, oe, boost, disc, latched;
  lsfh_vec_t sink;
  int        mismatches = 0;
  int        compares = 0;

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

  always #5 sys_clk_in = ~sys_clk_in;

  lsfh_top #(.UNLATCH_CYC(UNL)) dut (.sys_clk_in, .srst_in,
    .clk_en_in(1'h1), .mode_shut_all_in(mode), .enable_in(enable),
    .pwm_in(pwm), .above_thr_in(above), .regulating_in(regul),
    .below_low_in(below), .fault_line_in(line), .fault_line_out(fl_out),
    .fault_line_oe_out(oe), .boost_en_out(boost),
    .disconnect_on_out(disc), .sink_en_out(sink), .latched_out(latched));
  lsfh_host_model host (.pull_low_in(pull), .force_high_in(force_hi),
    .dev_oe_in(oe), .dev_data_in(fl_out), .line_out(line));

  // *****
  // Helpers
  // *****
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic rst(input logic m);
    srst_in = 1'h1;
    mode = m;
    pwm = 1'h0;
    above = 4'h0;
    below = 4'h0;
    cyc(6);
    srst_in = 1'h0;
    cyc(3);
  endtask
  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // *****
  // Scenarios
  // *****
  task automatic t_isolate();
    rst(1'h0);
    pwm = 1'h1;
    above = 4'h1;
    pull = 1'h1;
    cyc(3);
    `CHK({sink, boost, disc}, 6'h3F)
    pull = 1'h0;
    cyc(247);
    `CHK(sink, 4'hF)
    below = 4'h2;
    regul = 4'hE;
    cyc(250);
    `CHK(sink, 4'hF)
    regul = 4'hF;
    pwm = 1'h0;
    cyc(250);
    `CHK(sink, 4'hF)
    pwm = 1'h1;
    cyc(150);
    above = 4'h0;
    cyc(1);
    above = 4'h1;
    cyc(150);
    `CHK(sink, 4'hF)
    cyc(55);
    `CHK({sink, oe, boost}, 6'h3B)
    pull = 1'h1;
    cyc(3);
    `CHK({sink, boost}, 5'h1D)
    pull = 1'h0;
    pwm = 1'h0;
    cyc(2);
    pwm = 1'h1;
    cyc(2);
    `CHK(sink, 4'hF)
    cyc(203);
    `CHK({sink, oe}, 5'h1D)
    above = 4'h0;
    pwm = 1'h0;
    cyc(2);
    pwm = 1'h1;
    cyc(2);
    `CHK({sink, oe}, 5'h1F)
    pwm = 1'h0;
    cyc(2);
    pwm = 1'h1;
    cyc(3);
    `CHK(oe, 1'h0)
  endtask

  task automatic t_shut();
    int i;
    rst(1'h1);
    pull = 1'h1;
    cyc(2);
    `CHK({boost, sink, disc, oe}, 7'h02)
    pull = 1'h0;
    cyc(3);
    `CHK({boost, sink}, 5'h1F)
    pwm = 1'h1;
    above = 4'h1;
    below = 4'h2;
    cyc(203);
    `CHK({latched, oe, boost, sink}, 7'h60)
    force_hi = 1'h1;
    above = 4'h0;
    cyc(20);
    `CHK(latched, 1'h1)
    force_hi = 1'h0;
    enable = 1'h0;
    cyc(UNL - 5);
    `CHK(latched, 1'h1)
    for (i = 0; i < 30 && latched !== 1'h0; i++) cyc(1);
    if (latched !== 1'h0) begin
      mismatches++;
      stop_test();
    end
    enable = 1'h1;
    cyc(3);
    `CHK({latched, boost, sink}, 6'h1F)
  endtask

  initial begin
    t_isolate();
    t_shut();
    stop_test();
  end
endmodule

bind lsfh_top lsfh_top_sva #(.UNLATCH_CYC(UNLATCH_CYC)) u_sva (
  .sys_clk_in, .srst_in, .mode_shut_all_in, .enable_in, .pwm_in,
  .above_thr_in, .regulating_in, .below_low_in, .fault_line_in,
  .fault_line_out, .fault_line_oe_out, .boost_en_out, .disconnect_on_out,
  .sink_en_out, .latched_out);
